// File: shared/mcr_regs.svh
// Purpose: constants of the error reporting block
// Assumes: included by bare name
// Notes:   field positions of status words and fixed ids
`ifndef MCR_REGS_SVH
`define MCR_REGS_SVH

// feature flags word of the feature query instruction
`define MCR_FEAT_EXC_BIT   7
`define MCR_FEAT_ARCH_BIT  14

// global capability word
`define MCR_BANKS          5
`define MCR_CAP_COUNT      8'h05
`define MCR_CAP_CTLP_BIT   8

// fourth control register, exception enable bit
`define MCR_CTL4_EXC_BIT   6

// bank status word layout
`define MCR_ST_VALID       63
`define MCR_ST_OVER        62
`define MCR_ST_NOTC        61
`define MCR_ST_EN          60
`define MCR_ST_INFOV       59
`define MCR_ST_ADDRC       58
`define MCR_ST_CTXC        57
`define MCR_ST_TYPE_W      6

// global check status word layout
`define MCR_GS_RESTART     0
`define MCR_GS_ERRIP       1
`define MCR_GS_INPROG      2

// reset values
`define MCR_GCTL_RST       5'h00
`define MCR_BCTL_RST       64'h0000000000000000
`define MCR_WORD_RST       64'h0000000000000000

`endif

// File: shared/mcr_pkg.sv
// Purpose: types of the error reporting block
// Assumes: nothing
// Notes:   access selector and exception state codes
package mcr_pkg;
  typedef logic [63:0] mcr_word_t;
  typedef logic [2:0]  mcr_bank_t;
  // register selected by a software access
  typedef enum logic [2:0] {
    SEL_CAP   = 3'h0,
    SEL_GCTL  = 3'h1,
    SEL_GSTAT = 3'h2,
    SEL_BCTL  = 3'h3,
    SEL_BSTAT = 3'h4,
    SEL_BADDR = 3'h5,
    SEL_BINFO = 3'h6,
    SEL_CTL4  = 3'h7
  } mcr_sel_t;
  // exception sequencer states
  typedef enum logic [2:0] {
    EXC_IDLE     = 3'b001,
    EXC_HANDLER  = 3'b010,
    EXC_SHUTDOWN = 3'b100
  } mcr_exc_t;
endpackage

// File: shared/mcr_err_if.sv
// Purpose: carries one detected error to the banks
// Assumes: driven on ref_clk
// Notes:   one source, every bank listens
`timescale 1ns/100ps
interface mcr_err_if;
  import mcr_pkg::*;
  logic      valid;
  mcr_bank_t bank;
  logic [5:0] etype;
  logic      corrected;
  logic      ctx;
  logic      addr_ok;
  mcr_word_t addr;
  logic      info_ok;
  mcr_word_t info;
  modport src (output valid, bank, etype, corrected, ctx,
               output addr_ok, addr, info_ok, info);
  modport snk (input valid, bank, etype, corrected, ctx,
               input addr_ok, addr, info_ok, info);
endinterface

// File: design/mcr_bank.sv
// Purpose: one error reporting bank: status, address, extra info
// Assumes: resetn is power-on only; processor reset does not reach it
// Notes:   first error is kept, later ones only mark overflow
`timescale 1ns/100ps
`include "mcr_regs.svh"
module mcr_bank #(
  parameter logic [2:0] IDX = 3'h0
) (
  // clock and reset
  input  wire logic          ref_clk,
  input  wire logic          resetn,
  // error event
  mcr_err_if.snk             err,
  // controls
  input  wire logic          glob_en,
  input  wire mcr_pkg::mcr_word_t bank_en,
  input  wire logic          stat_wr,
  input  wire mcr_pkg::mcr_word_t wr_data,
  // state
  output mcr_pkg::mcr_word_t status,
  output mcr_pkg::mcr_word_t addr,
  output mcr_pkg::mcr_word_t info,
  output logic               report
);
  import mcr_pkg::*;

  // decode of the incoming event
  wire       hit     = err.valid && (err.bank == IDX) && glob_en;
  wire       type_en = bank_en[err.etype]; // RQ19
  wire       held    = status[`MCR_ST_VALID] && !stat_wr;
  wire       take    = hit && !held;
  wire [63:0] fresh  = {1'b1, 1'b0, !err.corrected, type_en,
                        err.info_ok, err.addr_ok, err.ctx, 51'h0,
                        err.etype}; // RQ12 RQ13 RQ15
  wire [63:0] over   = status | (64'h1 << `MCR_ST_OVER); // RQ8
  // a new error beats a clearing write in the same cycle
  wire [63:0] next_status = take ? fresh :
                            hit ? over :
                            stat_wr ? wr_data : status; // RQ17
  // corrected errors never ask for the exception
  assign report = hit && type_en && !err.corrected; // RQ7 RQ19

  // status survives the processor reset
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      status <= `MCR_WORD_RST;
      addr   <= `MCR_WORD_RST;
      info   <= `MCR_WORD_RST;
    end else begin
      status <= next_status; // RQ16
      if (take && err.addr_ok) addr <= err.addr; // RQ14
      if (take && err.info_ok) info <= err.info; // RQ14
    end
  end

  AST_BANK_LOG: // RQ15
  assert property (@(posedge ref_clk) disable iff (!resetn)
    take |=> status[`MCR_ST_VALID] &&
             status[`MCR_ST_TYPE_W-1:0] == $past(err.etype))
    else $error("bank did not log a fresh error");
  AST_BANK_OVER: // RQ8
  assert property (@(posedge ref_clk) disable iff (!resetn)
    (hit && held) |=> status[`MCR_ST_OVER] &&
                      $stable(status[`MCR_ST_TYPE_W-1:0]))
    else $error("second error did not set overflow");
  AST_BANK_ADDR: // RQ14
  assert property (@(posedge ref_clk) disable iff (!resetn)
    (take && err.addr_ok) |=> addr == $past(err.addr) &&
                               status[`MCR_ST_ADDRC])
    else $error("address not captured");
endmodule

// File: design/mcr_exc.sv
// Purpose: exception sequencer and global check status
// Assumes: core_rst is a processor reset on ref_clk
// Notes:   a second exception while in the handler shuts down
`timescale 1ns/100ps
`include "mcr_regs.svh"
module mcr_exc (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       core_rst,
  // exception request
  input  wire logic       any_report,
  input  wire logic       exc_en,
  input  wire logic       restart_ok,
  input  wire logic       ip_related,
  // software write of global status
  input  wire logic       gs_wr,
  input  wire logic [2:0] gs_wr_data,
  // results
  output logic            trap,
  output logic            shutdown,
  output logic [2:0]      gstat
);
  import mcr_pkg::*;

  mcr_exc_t  state;
  mcr_exc_t  next_state;
  logic      rip;
  logic      eip;

  wire raise = any_report && exc_en; // RQ5 RQ6
  wire sw_clr = gs_wr && !gs_wr_data[`MCR_GS_INPROG];
  wire sw_set = gs_wr && gs_wr_data[`MCR_GS_INPROG];

  // next state; a raise wins over the handler's clear
  always_comb begin
    next_state = state;
    case (state)
      EXC_IDLE: begin
        if (raise || sw_set) next_state = EXC_HANDLER; // RQ9
      end
      EXC_HANDLER: begin
        if (raise) next_state = EXC_SHUTDOWN; // RQ9
        else if (sw_clr) next_state = EXC_IDLE; // RQ18
      end
      EXC_SHUTDOWN: next_state = EXC_SHUTDOWN;
      default: next_state = EXC_IDLE;
    endcase
  end

  // state, trap pulse and restart flags
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= EXC_IDLE;
      trap  <= 1'b0;
      rip   <= 1'b0;
      eip   <= 1'b0;
    end else if (core_rst) begin
      state <= EXC_IDLE;
      trap  <= 1'b0;
      rip   <= 1'b0;
      eip   <= 1'b0;
    end else begin
      state <= next_state;
      trap  <= raise && (state == EXC_IDLE); // RQ6
      if (raise && state == EXC_IDLE) begin
        rip <= restart_ok; // RQ10
        eip <= ip_related; // RQ11
      end else if (gs_wr) begin
        rip <= gs_wr_data[`MCR_GS_RESTART];
        eip <= gs_wr_data[`MCR_GS_ERRIP];
      end
    end
  end

  assign shutdown = (state == EXC_SHUTDOWN);
  assign gstat    = {state != EXC_IDLE, eip, rip};

  sequence s_raise_idle;
    raise && state == EXC_IDLE && !core_rst;
  endsequence
  sequence s_trap_taken;
    trap && gstat[`MCR_GS_INPROG];
  endsequence
  AST_EXC_TRAP: // RQ6
  assert property (@(posedge ref_clk) disable iff (!resetn)
    s_raise_idle |=> s_trap_taken ##1 !trap)
    else $error("trap not one pulse after raise");
  AST_EXC_SHUT: // RQ9
  assert property (@(posedge ref_clk) disable iff (!resetn)
    (raise && state == EXC_HANDLER && !core_rst) |=> shutdown && !trap)
    else $error("nested exception did not shut down");
  AST_EXC_RIP: // RQ10
  assert property (@(posedge ref_clk) disable iff (!resetn)
    s_raise_idle |=> gstat[`MCR_GS_RESTART] == $past(restart_ok))
    else $error("restart flag not captured");
endmodule

// File: design/mcr_top.sv
// Purpose: machine check error reporting with five banks
// Assumes: all inputs come from core logic on ref_clk
// Notes:   resetn is power-on; core_rst keeps bank contents
// Function
// RQ1 - feature flags show exception bit 7 and architecture bit 14
// RQ2 - capability shows control present, global enables exist
// RQ3 - each global enable bit gates one bank; all ones enables all
// RQ4 - capability count reports five banks, numbered zero to four
// RQ5 - exception delivered only while control bit 6 is set
// RQ6 - uncorrected enabled error traps to the handler at once
// RQ7 - self-corrected errors are logged only, never trap
// RQ8 - second error on a held status sets overflow
// RQ9 - exception sets in-progress; another one meanwhile shuts down
// RQ10 - restart flag set only when resume is reliable
// RQ11 - error address flag set only when pointer relates to error
// RQ12 - not-corrected flag set when error was not corrected
// RQ13 - context-corrupt flag set when processor context is damaged
// RQ14 - address and extra info captured with their flags
// RQ15 - valid flag set on logging; status meaningless otherwise
// RQ16 - bank status survives a processor reset
// RQ17 - writing zero to bank status clears it
// RQ18 - handler clears in-progress and bank valid flags before return
// RQ19 - bank reports only enabled error types, banks independent
`timescale 1ns/100ps
`include "mcr_regs.svh"
module mcr_top (
  // clock and resets
  input  wire logic               ref_clk,
  input  wire logic               resetn,
  input  wire logic               core_rst,
  // detected error
  input  wire logic               err_valid,
  input  wire mcr_pkg::mcr_bank_t err_bank,
  input  wire logic [5:0]         err_type,
  input  wire logic               err_corrected,
  input  wire logic               err_ctx_corrupt,
  input  wire logic               err_addr_valid,
  input  wire mcr_pkg::mcr_word_t err_addr,
  input  wire logic               err_info_valid,
  input  wire mcr_pkg::mcr_word_t err_info,
  input  wire logic               err_restart_ok,
  input  wire logic               err_ip_related,
  // software write
  input  wire logic               sw_wr,
  input  wire mcr_pkg::mcr_sel_t  sw_wr_sel,
  input  wire mcr_pkg::mcr_bank_t sw_wr_bank,
  input  wire mcr_pkg::mcr_word_t sw_wr_data,
  // software read
  input  wire mcr_pkg::mcr_sel_t  sw_rd_sel,
  input  wire mcr_pkg::mcr_bank_t sw_rd_bank,
  output mcr_pkg::mcr_word_t      sw_rd_data,
  // fixed identification words
  output logic [31:0]             feature_flags,
  output mcr_pkg::mcr_word_t      global_capability,
  // exception
  output logic                    machine_check_trap,
  output logic                    shutdown
);
  import mcr_pkg::*;

  localparam int NB = `MCR_BANKS;

  // access decode, shared by writes of the five writable registers
  function automatic logic sel_hit(input logic     en,
                                   input mcr_sel_t got,
                                   input mcr_sel_t want);
    sel_hit = en && (got == want);
  endfunction

  // software-visible control
  logic [NB-1:0]        global_control_enables;
  logic                 check_exception_enable;
  mcr_word_t            bank_error_enables [NB];

  // bank outputs
  mcr_word_t            st   [NB];
  mcr_word_t            ad   [NB];
  mcr_word_t            inf  [NB];
  logic [NB-1:0]        rep;
  logic [2:0]           gstat;
  mcr_word_t            next_rd;

  // write strobes
  wire gctl_wr  = sel_hit(sw_wr, sw_wr_sel, SEL_GCTL);
  wire bctl_wr  = sel_hit(sw_wr, sw_wr_sel, SEL_BCTL);
  wire bstat_wr = sel_hit(sw_wr, sw_wr_sel, SEL_BSTAT);
  wire gs_wr    = sel_hit(sw_wr, sw_wr_sel, SEL_GSTAT);
  wire ctl4_wr  = sel_hit(sw_wr, sw_wr_sel, SEL_CTL4);
  wire rd_ok    = sw_rd_bank < 3'(NB);

  // fixed words; capability says enables register exists
  assign feature_flags = (32'h1 << `MCR_FEAT_EXC_BIT) |
                         (32'h1 << `MCR_FEAT_ARCH_BIT); // RQ1
  assign global_capability = {55'h0, 1'b1, `MCR_CAP_COUNT}; // RQ2 RQ4

  // error event onto the carrier
  mcr_err_if err ();
  assign err.valid     = err_valid;
  assign err.bank      = err_bank;
  assign err.etype     = err_type;
  assign err.corrected = err_corrected;
  assign err.ctx       = err_ctx_corrupt;
  assign err.addr_ok   = err_addr_valid;
  assign err.addr      = err_addr;
  assign err.info_ok   = err_info_valid;
  assign err.info      = err_info;

  // global enables and exception enable; processor reset clears
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      global_control_enables <= `MCR_GCTL_RST;
      check_exception_enable <= 1'b0;
    end else if (core_rst) begin
      global_control_enables <= `MCR_GCTL_RST;
      check_exception_enable <= 1'b0;
    end else begin
      if (gctl_wr) global_control_enables <= sw_wr_data[NB-1:0]; // RQ3
      if (ctl4_wr)
        check_exception_enable <= sw_wr_data[`MCR_CTL4_EXC_BIT]; // RQ5
    end
  end

  // one bank per index, each with its own enables
  for (genvar i = 0; i < NB; i++) begin : g_bank
    wire own_ctl  = bctl_wr && (sw_wr_bank == 3'(i));
    wire own_stat = bstat_wr && (sw_wr_bank == 3'(i));

    // per-bank enables; banks do not affect each other
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        bank_error_enables[i] <= `MCR_BCTL_RST;
      end else if (core_rst) begin
        bank_error_enables[i] <= `MCR_BCTL_RST;
      end else if (own_ctl) begin
        bank_error_enables[i] <= sw_wr_data; // RQ19
      end
    end

    mcr_bank #(
      .IDX (3'(i))
    ) u_bank (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .err     (err.snk),
      .glob_en (global_control_enables[i]), // RQ3
      .bank_en (bank_error_enables[i]),
      .stat_wr (own_stat),
      .wr_data (sw_wr_data),
      .status  (st[i]),
      .addr    (ad[i]),
      .info    (inf[i]),
      .report  (rep[i])
    );
  end

  // exception sequencer
  mcr_exc u_exc (
    .ref_clk    (ref_clk),
    .resetn     (resetn),
    .core_rst   (core_rst),
    .any_report (|rep), // RQ6
    .exc_en     (check_exception_enable),
    .restart_ok (err_restart_ok),
    .ip_related (err_ip_related),
    .gs_wr      (gs_wr),
    .gs_wr_data (sw_wr_data[2:0]),
    .trap       (machine_check_trap),
    .shutdown   (shutdown),
    .gstat      (gstat)
  );

  // read selection; missing banks read zero
  always_comb begin
    next_rd = `MCR_WORD_RST;
    case (sw_rd_sel)
      SEL_CAP:   next_rd = global_capability;
      SEL_GCTL:  next_rd = {59'h0, global_control_enables};
      SEL_GSTAT: next_rd = {61'h0, gstat};
      SEL_BCTL:  if (rd_ok) next_rd = bank_error_enables[sw_rd_bank];
      SEL_BSTAT: if (rd_ok) next_rd = st[sw_rd_bank];
      SEL_BADDR: if (rd_ok) next_rd = ad[sw_rd_bank];
      SEL_BINFO: if (rd_ok) next_rd = inf[sw_rd_bank];
      SEL_CTL4:
        next_rd = 64'(check_exception_enable) << `MCR_CTL4_EXC_BIT;
      default:   next_rd = `MCR_WORD_RST;
    endcase
  end

  // read data from a register: one cycle latency
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) sw_rd_data <= `MCR_WORD_RST;
    else sw_rd_data <= next_rd;
  end

  // helpers for the checks below
  wire b0_hit = err_valid && err_bank == 3'h0;
  // bank 0 stands in for every bank; a free bank takes the event
  wire b0_take = b0_hit && global_control_enables[0] &&
                 !st[0][`MCR_ST_VALID];
  wire b0_type_off = !bank_error_enables[0][err_type];
  // reads of a bank register, where the index may be missing
  wire rd_bank_sel = sw_rd_sel inside {SEL_BCTL, SEL_BSTAT,
                                       SEL_BADDR, SEL_BINFO};

  // processor reset and the controls it must leave cleared
  sequence s_core_reset;
    core_rst;
  endsequence
  sequence s_controls_off;
    global_control_enables == `MCR_GCTL_RST && !check_exception_enable;
  endsequence

  AST_FEATURE_BITS: // RQ1
  assert property (@(posedge ref_clk) disable iff (!resetn)
    feature_flags[`MCR_FEAT_EXC_BIT] && feature_flags[`MCR_FEAT_ARCH_BIT])
    else $error("feature flags missing");
  AST_CAP_WORD: // RQ4
  assert property (@(posedge ref_clk) disable iff (!resetn)
    global_capability[7:0] == 8'h05 &&
    global_capability[`MCR_CAP_CTLP_BIT])
    else $error("capability word wrong");
  AST_GCTL_ALL: // RQ3
  assert property (@(posedge ref_clk) disable iff (!resetn)
    (gctl_wr && !core_rst && sw_wr_data[4:0] == 5'h1f)
      |=> global_control_enables == 5'h1f)
    else $error("all ones did not enable all banks");
  AST_EXC_GATED: // RQ5
  assert property (@(posedge ref_clk) disable iff (!resetn)
    !check_exception_enable |=> !machine_check_trap)
    else $error("trap while exception disabled");
  AST_CORR_NO_TRAP: // RQ7
  assert property (@(posedge ref_clk) disable iff (!resetn)
    (err_valid && err_corrected) |=> !machine_check_trap)
    else $error("corrected error raised a trap");
  AST_CLEAR_ZERO: // RQ17
  assert property (@(posedge ref_clk) disable iff (!resetn)
    (bstat_wr && sw_wr_bank == 3'h0 && sw_wr_data == 64'h0 && !b0_hit)
      |=> st[0] == 64'h0)
    else $error("zero write did not clear status");
  AST_KEEP_CORE_RST: // RQ16
  assert property (@(posedge ref_clk) disable iff (!resetn)
    (core_rst && !err_valid && !bstat_wr) |=> $stable(st[0]))
    else $error("processor reset changed bank status");
  AST_RD_STATUS: // RQ15
  assert property (@(posedge ref_clk) disable iff (!resetn)
    (sw_rd_sel == SEL_BSTAT && sw_rd_bank == 3'h0)
      |=> sw_rd_data == $past(st[0]))
    else $error("status read wrong");

  // gating and controls
  AST_CORE_CLEARS: // RQ5
  assert property (@(posedge ref_clk) disable iff (!resetn)
    s_core_reset |=> s_controls_off)
    else $error("processor reset left controls set");
  AST_GLOBAL_GATE: // RQ3
  assert property (@(posedge ref_clk) disable iff (!resetn)
    (b0_hit && !global_control_enables[0] && !bstat_wr)
      |=> $stable(st[0]))
    else $error("disabled bank logged an error");
  AST_TYPE_GATE: // RQ19
  assert property (@(posedge ref_clk) disable iff (!resetn)
    (b0_hit && b0_type_off) |=> !machine_check_trap)
    else $error("disabled error type raised a trap");

  // fields of a freshly logged error; a held error is kept
  AST_NOT_CORR: // RQ12
  assert property (@(posedge ref_clk) disable iff (!resetn)
    b0_take |=> st[0][`MCR_ST_NOTC] == !$past(err_corrected))
    else $error("not-corrected flag wrong");
  AST_CTX_FLAG: // RQ13
  assert property (@(posedge ref_clk) disable iff (!resetn)
    b0_take |=> st[0][`MCR_ST_CTXC] == $past(err_ctx_corrupt))
    else $error("context-corrupt flag wrong");
  AST_INFO_CAPT: // RQ14
  assert property (@(posedge ref_clk) disable iff (!resetn)
    (b0_take && err_info_valid)
      |=> inf[0] == $past(err_info) && st[0][`MCR_ST_INFOV])
    else $error("extra info not captured");
  AST_FIRST_KEPT: // RQ8
  assert property (@(posedge ref_clk) disable iff (!resetn)
    (b0_hit && global_control_enables[0] && st[0][`MCR_ST_VALID] &&
     !bstat_wr) |=> $stable(ad[0]) && $stable(inf[0]))
    else $error("held error overwritten by a later one");

  // exception pulse, shutdown and error pointer flag
  AST_TRAP_PULSE: // RQ6
  assert property (@(posedge ref_clk) disable iff (!resetn)
    machine_check_trap |=> !machine_check_trap)
    else $error("trap longer than one cycle");
  AST_SHUT_HOLD: // RQ9
  assert property (@(posedge ref_clk) disable iff (!resetn)
    (shutdown && !core_rst) |=> shutdown)
    else $error("shutdown left without reset");
  AST_ERR_IP: // RQ11
  assert property (@(posedge ref_clk) disable iff (!resetn)
    machine_check_trap |-> gstat[`MCR_GS_ERRIP] == $past(err_ip_related))
    else $error("error pointer flag not captured");

  // read port
  AST_RD_MISSING: // RQ4
  assert property (@(posedge ref_clk) disable iff (!resetn)
    (rd_bank_sel && sw_rd_bank > 3'h4) |=> sw_rd_data == 64'h0)
    else $error("missing bank read not zero");
  AST_RD_CTL4: // RQ5
  assert property (@(posedge ref_clk) disable iff (!resetn)
    sw_rd_sel == SEL_CTL4
      |=> sw_rd_data[`MCR_CTL4_EXC_BIT] == $past(check_exception_enable))
    else $error("exception enable read wrong");
endmodule

// File: tb/mcr_top_test.sv
// Purpose: self-checking bench for the error reporting block
// Assumes: one-cycle answers for trap, status writes and read data
// Notes:   a bit-array reference model predicts every compared value
`timescale 1ns/100ps
`include "mcr_regs.svh"
module mcr_top_test;
  import mcr_pkg::*;
  logic        ref_clk, resetn, core_rst, sw_wr;
  logic        err_valid, err_corrected, err_ctx_corrupt, err_addr_valid;
  logic        err_info_valid, err_restart_ok, err_ip_related;
  logic        machine_check_trap, shutdown;
  logic [5:0]  err_type;
  logic [31:0] feature_flags;
  mcr_bank_t   err_bank, sw_wr_bank, sw_rd_bank;
  mcr_sel_t    sw_wr_sel, sw_rd_sel;
  mcr_word_t   err_addr, err_info, sw_wr_data, sw_rd_data;
  mcr_word_t   global_capability;
  int          err_count, checked;
  int unsigned seed;
  // model state; banks 5..7 stay zero so refused reads expect zero
  bit [63:0]   m_stat [8];
  bit [63:0]   m_addr [8];
  bit [63:0]   m_info [8];
  bit [63:0]   m_bctl [8];
  bit [4:0]    m_gctl;
  bit [2:0]    m_gs;
  bit          m_ctl4, m_shut;

  mcr_top i_dut (.ref_clk(ref_clk), .resetn(resetn), .core_rst(core_rst),
    .err_valid(err_valid), .err_bank(err_bank), .err_type(err_type),
    .err_corrected(err_corrected), .err_ctx_corrupt(err_ctx_corrupt),
    .err_addr_valid(err_addr_valid), .err_addr(err_addr),
    .err_info_valid(err_info_valid), .err_info(err_info),
    .err_restart_ok(err_restart_ok), .err_ip_related(err_ip_related),
    .sw_wr(sw_wr), .sw_wr_sel(sw_wr_sel), .sw_wr_bank(sw_wr_bank),
    .sw_wr_data(sw_wr_data), .sw_rd_sel(sw_rd_sel),
    .sw_rd_bank(sw_rd_bank), .sw_rd_data(sw_rd_data),
    .feature_flags(feature_flags), .global_capability(global_capability),
    .machine_check_trap(machine_check_trap), .shutdown(shutdown));

  // free-running 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  // xorshift source, fixed start
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input mcr_word_t got, input mcr_word_t exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // inputs always move 1 ns after the edge
  task automatic cyc();
    @(posedge ref_clk);
    #1;
  endtask

  task automatic done(input string name);
    $display("test %s finished, mismatches so far %0d", name, err_count);
  endtask

  // one write; the idle cycle after it keeps strobes one-per-step
  task automatic wr(input mcr_sel_t s, input int b, input mcr_word_t d);
    sw_wr = 1'b1;
    sw_wr_sel = s;
    sw_wr_bank = 3'(b);
    sw_wr_data = d;
    if (s == SEL_GCTL) m_gctl = d[4:0];
    if (s == SEL_GSTAT) m_gs = {m_shut | d[2], d[1:0]};
    if (s == SEL_CTL4) m_ctl4 = d[6];
    if (b < 5 && s == SEL_BCTL) m_bctl[b] = d;
    if (b < 5 && s == SEL_BSTAT) m_stat[b] = d;
    cyc();
    sw_wr = 1'b0;
    cyc();
  endtask

  function automatic mcr_word_t mexp(input mcr_sel_t s, input int b);
    mcr_word_t v;
    v = '0;
    case (s)
      SEL_CAP:   v = 64'h0000000000000105;
      SEL_GCTL:  v[4:0] = m_gctl;
      SEL_GSTAT: v[2:0] = m_gs;
      SEL_CTL4:  v[6] = m_ctl4;
      SEL_BCTL:  v = m_bctl[b];
      SEL_BSTAT: v = m_stat[b];
      SEL_BADDR: v = m_addr[b];
      default:   v = m_info[b];
    endcase
    return v;
  endfunction

  // read data shows the selected register one edge later
  task automatic rd(input mcr_sel_t s, input int b);
    sw_rd_sel = s;
    sw_rd_bank = 3'(b);
    cyc();
    chk(sw_rd_data, mexp(s, b));
  endtask

  // f = {corrected, ctx corrupt, addr ok, info ok, restart ok, ip related}
  task automatic fire(input int b, input int t, input bit [5:0] f);
    bit raise;
    bit trap_exp;
    raise = 1'b0;
    {err_corrected, err_ctx_corrupt, err_addr_valid} = f[5:3];
    {err_info_valid, err_restart_ok, err_ip_related} = f[2:0];
    err_bank = 3'(b);
    err_type = 6'(t);
    err_addr = {rnd(), rnd()};
    err_info = {rnd(), rnd()};
    err_valid = 1'b1;
    if (b < 5 && m_gctl[b]) begin
      if (m_stat[b][`MCR_ST_VALID]) begin
        m_stat[b][`MCR_ST_OVER] = 1'b1;
      end else begin
        m_stat[b] = {58'h0, err_type};
        m_stat[b][`MCR_ST_VALID] = 1'b1;
        m_stat[b][`MCR_ST_NOTC] = !f[5];
        m_stat[b][`MCR_ST_EN] = m_bctl[b][err_type];
        m_stat[b][`MCR_ST_INFOV] = f[2];
        m_stat[b][`MCR_ST_ADDRC] = f[3];
        m_stat[b][`MCR_ST_CTXC] = f[4];
        if (f[3]) m_addr[b] = err_addr;
        if (f[2]) m_info[b] = err_info;
      end
      raise = !f[5] && m_bctl[b][err_type] && m_ctl4 && !m_shut;
    end
    trap_exp = raise && !m_gs[2];
    if (raise && m_gs[2]) m_shut = 1'b1;
    if (trap_exp) m_gs = {1'b1, f[0], f[1]};
    cyc();
    err_valid = 1'b0;
    chk({63'h0, machine_check_trap}, {63'h0, trap_exp});
    chk({63'h0, shutdown}, {63'h0, m_shut});
    cyc();
    chk({63'h0, machine_check_trap}, 64'h0);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    #1000000;
    err_count++;
    tally_and_finish();
  end

  initial begin
    {ref_clk, resetn, core_rst, sw_wr, err_valid} = '0;
    {err_corrected, err_ctx_corrupt, err_addr_valid} = '0;
    {err_info_valid, err_restart_ok, err_ip_related} = '0;
    {err_bank, sw_wr_bank, sw_rd_bank, err_type} = '0;
    {err_addr, err_info, sw_wr_data} = '0;
    sw_wr_sel = SEL_CAP;
    sw_rd_sel = SEL_CAP;
    seed = 54295;
    repeat (16) @(posedge ref_clk);
    #1 resetn = 1'b1;
    // fixed identification words and refused writes
    chk({32'h0, feature_flags}, 64'h0000000000004080);
    chk(global_capability, 64'h0000000000000105);
    rd(SEL_CAP, 0);
    wr(SEL_GCTL, 0, '1);
    for (int b = 0; b < 6; b++) begin
      wr(SEL_BCTL, b, '1);
      wr(SEL_BSTAT, b, '0);
      rd(SEL_BCTL, b);
      rd(SEL_BSTAT, b);
    end
    wr(SEL_CTL4, 0, 64'h40);
    wr(SEL_CAP, 0, '0);
    rd(SEL_CAP, 0);
    rd(SEL_GCTL, 0);
    rd(SEL_CTL4, 0);
    done("setup");
    // uncorrected error, then a second one inside the handler
    fire(2, 6'h11, 6'b011111);
    rd(SEL_BSTAT, 2);
    rd(SEL_BADDR, 2);
    rd(SEL_BINFO, 2);
    rd(SEL_GSTAT, 0);
    fire(2, 6'h05, 6'b000000);
    rd(SEL_BSTAT, 2);
    wr(SEL_BADDR, 2, '0);
    rd(SEL_BADDR, 2);
    wr(SEL_GSTAT, 0, '0);
    rd(SEL_GSTAT, 0);
    // processor reset clears controls but keeps bank contents
    core_rst = 1'b1;
    cyc();
    core_rst = 1'b0;
    m_gctl = '0;
    m_gs = '0;
    m_ctl4 = 1'b0;
    m_shut = 1'b0;
    for (int b = 0; b < 5; b++) m_bctl[b] = '0;
    cyc();
    chk({63'h0, shutdown}, 64'h0);
    rd(SEL_BSTAT, 2);
    wr(SEL_BINFO, 2, '0);
    rd(SEL_BINFO, 2);
    rd(SEL_GCTL, 0);
    done("trap");
    // gating by global, type and exception enables
    wr(SEL_GCTL, 0, 64'h1a);
    wr(SEL_BCTL, 0, 64'h1);
    wr(SEL_BCTL, 1, '1);
    wr(SEL_BCTL, 4, '1);
    wr(SEL_BSTAT, 4, '0);
    fire(1, 3, 6'b000000);
    wr(SEL_CTL4, 0, 64'h40);
    fire(2, 0, 6'b010000);
    fire(0, 1, 6'b000000);
    fire(3, 1, 6'b000000);
    fire(4, 7, 6'b100000);
    for (int b = 0; b < 5; b++) rd(SEL_BSTAT, b);
    wr(SEL_GSTAT, 0, 64'h4);
    rd(SEL_GSTAT, 0);
    wr(SEL_GSTAT, 0, '0);
    done("gate");
    // random traffic; handler leaves after every trap
    wr(SEL_GCTL, 0, '1);
    for (int b = 0; b < 5; b++) begin
      wr(SEL_BCTL, b, {rnd(), rnd()});
      wr(SEL_BSTAT, b, '0);
    end
    for (int i = 0; i < 60; i++) begin
      fire(rnd() % 6, rnd(), rnd());
      if (m_gs[2]) wr(SEL_GSTAT, 0, 64'(rnd() & 3));
      if (rnd() % 3 == 0) wr(SEL_BSTAT, i % 5, '0);
      rd(SEL_BSTAT, i % 6);
    end
    for (int b = 0; b < 6; b++) begin
      rd(SEL_BSTAT, b);
      rd(SEL_GSTAT, 0);
      if (m_stat[b][`MCR_ST_ADDRC]) rd(SEL_BADDR, b);
      if (m_stat[b][`MCR_ST_INFOV]) rd(SEL_BINFO, b);
    end
    done("random");
    tally_and_finish();
  end
endmodule
